// ---- emulator_pod_register_control.sv ----
// Emulator pod register selector, control register and vector jam
//
// Function
// - Bus cycle indication in both polarities
// - Pod read places addressed register on data
// - Trace-only bit shows DMA cycles only on handshake, no response
// - Flag target space, steer data buffers
// - Jam four break bytes on vector read
// - Request-block bit gates target bus requests
// - Selector bit 7 resets DMA arbiter
// - Interlock bit demands target acknowledge first
// - Transmit low drives pod data to board
// - Even/odd select receive upper/lower data bytes
// - In-target indication feeds arbiter and break
// - Crystal select bit picks 10 MHz clock
// - Interrupt allow off masks all target levels; allowed break still raises level 7
// - Read strobe low when read, halt, defib
// - Selector bit 0 targets control register
// - Selector bits 1-4 target vector bytes
// - Level 7 sharing bit feeds break logic
// - Two-bit wait field sets wait states
// - Latches transparent when defib or read false
// - Break allow enables level 7 break interrupt
// - DMA hide bit hides DMA, blocks response
`timescale 1ns/1ps
`default_nettype none
`include "pod_consts.svh"
module emulator_pod_register_control (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Mainframe register port
  input  wire logic         selectorWrite,
  input  wire logic         podRegWrite,
  input  wire pod_pkg::pod_byte_type boardDataIn,
  input  wire logic [1:0]   boardDataHiIn,
  input  wire logic         podReadReq,
  input  wire logic         boardReceiveEn,
  output logic [7:0]        podDataOut,
  output logic [1:0]        podDataHiOut,
  output logic              pod_to_board_drive_n,
  output logic              upper_byte_receive_n,
  output logic              lower_byte_receive_n,
  output logic              pod_read_strobe_n,
  output logic              latch_pass_through,
  // Emulation bus
  input  wire logic         addrStrobe_n,
  input  wire logic         userMapHit,
  input  wire logic         dmaCycle,
  input  wire logic         dmaHandshake,
  input  wire logic         vector_jam_request_n,
  input  wire logic         halt_term_n,
  input  wire logic         defib_term,
  input  wire logic         emulAckIn,
  input  wire logic         target_transfer_ack_n,
  output logic              bus_cycle_active,
  output logic              bus_cycle_active_n,
  output logic              target_space_hit,
  output logic              userBufToTarget,
  output logic [7:0]        vectorByteOut,
  output logic              vector_byte0_drive_n,
  output logic              vector_byte1_drive_n,
  output logic              vector_byte2_drive_n,
  output logic              vector_byte3_drive_n,
  output logic              procAck,
  // Analysis and emulation memory
  output logic              analysisSeeCycle,
  output logic              emulMemRespond,
  // Arbiter, clock, interrupts and break
  input  wire logic         targetBusReq,
  input  wire logic [2:0]   targetIrqLevel_n,
  input  wire logic         breakRequest,
  input  wire logic         in_target_present_n,
  output logic              arbiterBusReq,
  output logic              arbiter_clear_n,
  output logic              arbiterInTarget,
  output logic              crystal_clock_select_n,
  output logic              useCrystalClock,
  output logic [2:0]        procIrqLevel_n,
  output logic              breakInTarget,
  output logic              level7_sharing_n,
  output logic              break_irq_allow,
  output logic              ack_interlock_n,
  output logic [1:0]        wait_state_count_n
);
  import pod_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0]   selector_r;
  logic [9:0]   control_r;
  pod_byte_type vecByte [4];
  logic [3:0]   vecWr;
  logic         ctlWr;

  assign ctlWr = podRegWrite && selector_r[`SEL_CTRL_BIT];
  // vector byte selects, bit 1 is high byte
  assign vecWr[0] = podRegWrite && selector_r[`SEL_VEC_HI_BIT];
  assign vecWr[1] = podRegWrite && selector_r[`SEL_VEC_UM_BIT];
  assign vecWr[2] = podRegWrite && selector_r[`SEL_VEC_LM_BIT];
  assign vecWr[3] = podRegWrite && selector_r[`SEL_VEC_LO_BIT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      selector_r <= `SEL_RESET;
    end else if (selectorWrite) begin
      selector_r <= boardDataIn;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_r <= `CTL_RESET;
    end else if (ctlWr) begin
      control_r <= {boardDataHiIn, boardDataIn};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_vec
      pod_byte_reg u_vec (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wrEn    (vecWr[gi]),
        .wrData  (boardDataIn),
        .value   (vecByte[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rdByte;
  logic [1:0] rdHi;
  logic       rdStrobe;
  logic       txActive;
  // strobe only when all three terms true
  assign rdStrobe = podReadReq && !halt_term_n && defib_term;
  // addressed register; software keeps one select bit set
  assign rdByte = selector_r[`SEL_CTRL_BIT]   ? control_r[7:0] :
                  selector_r[`SEL_VEC_HI_BIT] ? vecByte[0] :
                  selector_r[`SEL_VEC_UM_BIT] ? vecByte[1] :
                  selector_r[`SEL_VEC_LM_BIT] ? vecByte[2] :
                  selector_r[`SEL_VEC_LO_BIT] ? vecByte[3] : selector_r;
  assign rdHi   = selector_r[`SEL_CTRL_BIT] ? control_r[9:8] : 2'h0;
  assign txActive = rdStrobe;

  // ----------------------------------------
  // Vector jam sequencer
  // ----------------------------------------
  jam_state_type jam_r;
  jam_state_type jam_nxt;
  logic [1:0]    jamIdx_r;
  logic [1:0]    jamIdx_nxt;
  logic          jamReq;
  assign jamReq = !vector_jam_request_n && !addrStrobe_n;
  always_comb begin
    jam_nxt    = jam_r;
    jamIdx_nxt = jamIdx_r;
    case (jam_r)
      JAM_IDLE: begin
        jamIdx_nxt = 2'h0;
        if (jamReq) begin
          jam_nxt = JAM_BYTE;
        end
      end
      JAM_BYTE: begin
        if (!jamReq) begin
          jam_nxt = JAM_IDLE;
        end else if (jamIdx_r == 2'h3) begin
          jam_nxt = JAM_DONE;
        end else begin
          jamIdx_nxt = jamIdx_r + 2'h1;
        end
      end
      JAM_DONE: begin
        if (!jamReq) begin
          jam_nxt = JAM_IDLE;
        end
      end
      default: jam_nxt = JAM_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jam_r    <= JAM_IDLE;
      jamIdx_r <= 2'h0;
    end else begin
      jam_r    <= jam_nxt;
      jamIdx_r <= jamIdx_nxt;
    end
  end

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  logic cycleNow;
  logic hideDma;
  logic dmaSeen;
  logic ackReady;
  logic waitAck;
  logic [2:0] irqMasked;
  logic breakNow;
  assign cycleNow = !addrStrobe_n;
  // trace-only and hide both block response
  assign hideDma  = control_r[`CTL_DMA_BLOCK] || control_r[`CTL_TRACE_ONLY];
  assign dmaSeen  = !dmaCycle ? cycleNow :
                    control_r[`CTL_DMA_BLOCK]  ? 1'b0 :
                    control_r[`CTL_TRACE_ONLY] ? dmaHandshake : cycleNow;
  assign ackReady = emulAckIn &&
                    (control_r[`CTL_ACK_LOCK_N] || !target_transfer_ack_n);
  assign irqMasked = control_r[`CTL_IRQ_ALLOW_N] ? 3'h7 : targetIrqLevel_n;
  // break raises level 7 only when allowed
  assign breakNow = breakRequest && control_r[`CTL_BRK_ALLOW];

  pod_wait_gen u_wait (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .cycleActive (cycleNow),
    .ackIn       (ackReady),
    .waitCount   (~control_r[`CTL_WAIT_HI:`CTL_WAIT_LO]),
    .ackOut      (waitAck)
  );

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      podDataOut             <= 8'h00;
      podDataHiOut           <= 2'h0;
      pod_to_board_drive_n   <= 1'b1;
      upper_byte_receive_n   <= 1'b1;
      lower_byte_receive_n   <= 1'b1;
      pod_read_strobe_n      <= 1'b1;
      latch_pass_through     <= 1'b1;
      bus_cycle_active       <= 1'b0;
      bus_cycle_active_n     <= 1'b1;
      target_space_hit       <= 1'b0;
      userBufToTarget        <= 1'b0;
      vectorByteOut          <= 8'h00;
      vector_byte0_drive_n   <= 1'b1;
      vector_byte1_drive_n   <= 1'b1;
      vector_byte2_drive_n   <= 1'b1;
      vector_byte3_drive_n   <= 1'b1;
      procAck                <= 1'b0;
      analysisSeeCycle       <= 1'b0;
      emulMemRespond         <= 1'b0;
      arbiterBusReq          <= 1'b0;
      arbiter_clear_n        <= 1'b1;
      arbiterInTarget        <= 1'b0;
      crystal_clock_select_n <= 1'b1;
      useCrystalClock        <= 1'b0;
      procIrqLevel_n         <= 3'h7;
      breakInTarget          <= 1'b0;
      level7_sharing_n       <= 1'b1;
      break_irq_allow        <= 1'b0;
      ack_interlock_n        <= 1'b1;
      wait_state_count_n     <= 2'h3;
    end else begin
      podDataOut             <= rdStrobe ? rdByte : 8'h00;
      podDataHiOut           <= rdStrobe ? rdHi : 2'h0;
      pod_to_board_drive_n   <= !txActive;
      upper_byte_receive_n   <= !(boardReceiveEn && podRegWrite);
      lower_byte_receive_n   <= !(boardReceiveEn && (podRegWrite || selectorWrite));
      pod_read_strobe_n      <= !rdStrobe;
      latch_pass_through     <= !defib_term || !podReadReq;
      bus_cycle_active       <= cycleNow;
      bus_cycle_active_n     <= !cycleNow;
      target_space_hit       <= userMapHit && cycleNow;
      userBufToTarget        <= userMapHit && cycleNow;
      vectorByteOut          <= (jam_r == JAM_BYTE) ? vecByte[jamIdx_r] : 8'h00;
      vector_byte0_drive_n   <= !(jam_r == JAM_BYTE && jamIdx_r == 2'h0);
      vector_byte1_drive_n   <= !(jam_r == JAM_BYTE && jamIdx_r == 2'h1);
      vector_byte2_drive_n   <= !(jam_r == JAM_BYTE && jamIdx_r == 2'h2);
      vector_byte3_drive_n   <= !(jam_r == JAM_BYTE && jamIdx_r == 2'h3);
      procAck                <= waitAck && !(dmaCycle && hideDma);
      analysisSeeCycle       <= dmaSeen;
      // no memory response to hidden DMA
      emulMemRespond         <= cycleNow && !(dmaCycle && hideDma);
      arbiterBusReq          <= targetBusReq && !control_r[`CTL_REQ_BLOCK];
      arbiter_clear_n        <= !selector_r[`SEL_CLEAR_BIT];
      arbiterInTarget        <= !in_target_present_n;
      breakInTarget          <= !in_target_present_n;
      crystal_clock_select_n <= control_r[`CTL_XTAL_N];
      useCrystalClock        <= !control_r[`CTL_XTAL_N];
      // level 7 break wins over target levels
      procIrqLevel_n         <= breakNow ? 3'h0 : irqMasked;
      level7_sharing_n       <= control_r[`CTL_SHARE_N];
      break_irq_allow        <= control_r[`CTL_BRK_ALLOW];
      ack_interlock_n        <= control_r[`CTL_ACK_LOCK_N];
      wait_state_count_n     <= control_r[`CTL_WAIT_HI:`CTL_WAIT_LO];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cycle_both_pol: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_cycle_active != bus_cycle_active_n) else $error("cycle polarities equal");
  a_strobe_terms: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rdStrobe |=> !pod_read_strobe_n && !pod_to_board_drive_n)
    else $error("read strobe missing");
  a_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rdStrobe && selector_r[`SEL_CTRL_BIT] |=> podDataOut == $past(control_r[7:0]))
    else $error("control read wrong");
  a_arb_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    selector_r[`SEL_CLEAR_BIT] |=> !arbiter_clear_n) else $error("arbiter not cleared");
  a_req_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    control_r[`CTL_REQ_BLOCK] |=> !arbiterBusReq) else $error("request passed");
  a_dma_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dmaCycle && hideDma |=> !emulMemRespond) else $error("memory answered DMA");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    control_r[`CTL_IRQ_ALLOW_N] && !breakNow |=> procIrqLevel_n == 3'h7)
    else $error("interrupt not masked");
  a_jam_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    jam_r == JAM_IDLE && jamReq ##1 jamReq |=> !vector_byte0_drive_n &&
    vectorByteOut == $past(vecByte[0])) else $error("high vector byte not first");
  a_transparent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !defib_term |=> latch_pass_through) else $error("latch not transparent");
endmodule // emulator_pod_register_control
`default_nettype wire

// ---- emulator_pod_register_control_tb.sv ----
// Self-checking bench for the emulator pod register control
`timescale 1ns/1ps
`default_nettype none
module emulator_pod_register_control_tb;
  import pod_pkg::*;
  logic clk_sys, rst_n, selectorWrite, podRegWrite, podReadReq, boardReceiveEn;
  pod_byte_type boardDataIn;
  logic [1:0] boardDataHiIn, podDataHiOut, wait_state_count_n;
  logic [7:0] podDataOut, vectorByteOut;
  logic [2:0] targetIrqLevel_n, procIrqLevel_n;
  logic pod_to_board_drive_n, upper_byte_receive_n, lower_byte_receive_n, pod_read_strobe_n;
  logic latch_pass_through, addrStrobe_n, userMapHit, dmaCycle, dmaHandshake;
  logic vector_jam_request_n, halt_term_n, defib_term, emulAckIn, target_transfer_ack_n;
  logic bus_cycle_active, bus_cycle_active_n, target_space_hit, userBufToTarget;
  logic vector_byte0_drive_n, vector_byte1_drive_n, vector_byte2_drive_n, vector_byte3_drive_n;
  logic procAck, analysisSeeCycle, emulMemRespond, targetBusReq, breakRequest;
  logic in_target_present_n, arbiterBusReq, arbiter_clear_n, arbiterInTarget;
  logic crystal_clock_select_n, useCrystalClock, breakInTarget, level7_sharing_n;
  logic break_irq_allow, ack_interlock_n, respond;
  int fails, compares, cycles;
  pod_byte_type vec [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
  logic [9:0] ctlTab [3] = '{10'h000, 10'h3FF, 10'h3FA};

  emulator_pod_register_control emulator_pod_register_control_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .selectorWrite(selectorWrite),
    .podRegWrite(podRegWrite), .boardDataIn(boardDataIn), .boardDataHiIn(boardDataHiIn),
    .podReadReq(podReadReq), .boardReceiveEn(boardReceiveEn), .podDataOut(podDataOut),
    .podDataHiOut(podDataHiOut), .pod_to_board_drive_n(pod_to_board_drive_n),
    .upper_byte_receive_n(upper_byte_receive_n),
    .lower_byte_receive_n(lower_byte_receive_n), .pod_read_strobe_n(pod_read_strobe_n),
    .latch_pass_through(latch_pass_through), .addrStrobe_n(addrStrobe_n),
    .userMapHit(userMapHit), .dmaCycle(dmaCycle), .dmaHandshake(dmaHandshake),
    .vector_jam_request_n(vector_jam_request_n), .halt_term_n(halt_term_n),
    .defib_term(defib_term), .emulAckIn(emulAckIn),
    .target_transfer_ack_n(target_transfer_ack_n), .bus_cycle_active(bus_cycle_active),
    .bus_cycle_active_n(bus_cycle_active_n), .target_space_hit(target_space_hit),
    .userBufToTarget(userBufToTarget), .vectorByteOut(vectorByteOut),
    .vector_byte0_drive_n(vector_byte0_drive_n),
    .vector_byte1_drive_n(vector_byte1_drive_n),
    .vector_byte2_drive_n(vector_byte2_drive_n),
    .vector_byte3_drive_n(vector_byte3_drive_n),
    .procAck(procAck), .analysisSeeCycle(analysisSeeCycle), .emulMemRespond(emulMemRespond),
    .targetBusReq(targetBusReq), .targetIrqLevel_n(targetIrqLevel_n),
    .breakRequest(breakRequest), .in_target_present_n(in_target_present_n),
    .arbiterBusReq(arbiterBusReq), .arbiter_clear_n(arbiter_clear_n),
    .arbiterInTarget(arbiterInTarget), .crystal_clock_select_n(crystal_clock_select_n),
    .useCrystalClock(useCrystalClock), .procIrqLevel_n(procIrqLevel_n),
    .breakInTarget(breakInTarget), .level7_sharing_n(level7_sharing_n),
    .break_irq_allow(break_irq_allow), .ack_interlock_n(ack_interlock_n),
    .wait_state_count_n(wait_state_count_n));
  target_ack_model #(.ACK_DELAY(3)) target_ack_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .busCycle(bus_cycle_active),
    .respond(respond), .target_transfer_ack_n(target_transfer_ack_n));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic sel, input logic [9:0] d);
    @(posedge clk_sys);
    selectorWrite <= sel;
    podRegWrite <= !sel;
    {boardDataHiIn, boardDataIn} <= d;
    @(posedge clk_sys);
    selectorWrite <= 1'b0;
    podRegWrite <= 1'b0;
    #1;
    chk("upper_receive", upper_byte_receive_n, sel);
    chk("lower_receive", lower_byte_receive_n, 0);
  endtask
  task automatic rd(input string what, input logic [9:0] exp);
    @(posedge clk_sys);
    podReadReq <= 1'b1;
    halt_term_n <= 1'b0;
    defib_term <= 1'b1;
    tick();
    chk(what, {podDataHiOut, podDataOut}, exp);
    chk("read_strobe", pod_read_strobe_n, 0);
    chk("to_board", pod_to_board_drive_n, 0);
    chk("pass_through", latch_pass_through, 0);
    @(posedge clk_sys);
    podReadReq <= 1'b0;
    halt_term_n <= 1'b1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("arb_clear", arbiter_clear_n, 1);
    chk("wait_field", wait_state_count_n, 3);
    chk("interlock", ack_interlock_n, 1);
    wr(1, 10'h001);
    rd("ctl_reset", 10'h3F8);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      wr(1, 10'(2 << i));
      wr(0, {2'b00, vec[i]});
      rd("vector", {2'b00, vec[i]});
    end
    wr(1, 10'h081);
    wr(0, 10'h2A5);
    tick();
    chk("arb_clear_on", arbiter_clear_n, 0);
    rd("ctl_pair", 10'h2A5);
    wr(1, 10'h001);
    tick();
    chk("arb_clear_off", arbiter_clear_n, 1);
  endtask
  task automatic t_fields();
    logic [9:0] v;
    for (int k = 0; k < 3; k++) begin
      v = ctlTab[k];
      wr(0, v);
      @(posedge clk_sys);
      targetBusReq <= 1'b1;
      targetIrqLevel_n <= 3'h2;
      breakRequest <= (k != 1);
      dmaHandshake <= (k == 2);
      dmaCycle <= 1'b1;
      addrStrobe_n <= 1'b0;
      tick();
      tick();
      chk("xtal_n", crystal_clock_select_n, v[4]);
      chk("xtal", useCrystalClock, !v[4]);
      chk("share_n", level7_sharing_n, v[6]);
      chk("brk_allow", break_irq_allow, v[7]);
      chk("interlock", ack_interlock_n, v[3]);
      chk("wait_field", wait_state_count_n, v[9:8]);
      chk("bus_req", arbiterBusReq, !v[2]);
      chk("irq", procIrqLevel_n, (k != 1 && v[7]) ? 3'h0 : (v[5] ? 3'h7 : 3'h2));
      chk("analysis", analysisSeeCycle, !v[0] && (!v[1] || k == 2));
      chk("emul_resp", emulMemRespond, v[1:0] == 2'b00);
    end
    @(posedge clk_sys);
    breakRequest <= 1'b0;
    dmaHandshake <= 1'b0;
    dmaCycle <= 1'b0;
    addrStrobe_n <= 1'b1;
  endtask
  task automatic t_glue();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      addrStrobe_n <= i[0];
      in_target_present_n <= i[0];
      podReadReq <= i[0];
      userMapHit <= i[1];
      defib_term <= i[1];
      tick();
      chk("cycle", bus_cycle_active, !i[0]);
      chk("cycle_n", bus_cycle_active_n, i[0]);
      chk("space", target_space_hit, i[1] && !i[0]);
      chk("buf_dir", userBufToTarget, i[1] && !i[0]);
      chk("in_tgt", {arbiterInTarget, breakInTarget}, {2{!i[0]}});
      chk("pass", latch_pass_through, !(i[1] && i[0]));
      chk("strobe_idle", pod_read_strobe_n, 1);
    end
    @(posedge clk_sys);
    podReadReq <= 1'b0;
  endtask
  task automatic t_jam();
    int n;
    @(posedge clk_sys);
    vector_jam_request_n <= 1'b0;
    addrStrobe_n <= 1'b0;
    n = 0;
    while (vector_byte0_drive_n !== 1'b0 && n < 10) begin
      tick();
      n++;
    end
    for (int i = 0; i < 4; i++) begin
      chk("jam_lines", {vector_byte3_drive_n, vector_byte2_drive_n, vector_byte1_drive_n,
                        vector_byte0_drive_n}, 4'(~(4'b0001 << i)));
      chk("jam_byte", vectorByteOut, vec[i]);
      tick();
    end
    @(posedge clk_sys);
    vector_jam_request_n <= 1'b1;
    addrStrobe_n <= 1'b1;
  endtask
  task automatic ackWait(input logic [9:0] ctl, output int n);
    wr(0, ctl);
    @(posedge clk_sys);
    addrStrobe_n <= 1'b0;
    emulAckIn <= 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while (procAck !== 1'b1 && n < 14);
    @(posedge clk_sys);
    addrStrobe_n <= 1'b1;
    emulAckIn <= 1'b0;
    repeat (3) tick();
  endtask
  task automatic t_ack();
    int a, b, c;
    ackWait(10'h3F8, a);
    ackWait(10'h0F8, b);
    chk("ack_seen", a < 14, 1);
    chk("wait_span", 10'(b - a), 3);
    ackWait(10'h3F0, c);
    chk("interlock_hold", 10'(c), 14);
    respond <= 1'b1;
    ackWait(10'h3F0, c);
    chk("interlock_go", c < 14, 1);
  endtask

  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {selectorWrite, podRegWrite, podReadReq, userMapHit, dmaCycle, dmaHandshake} = '0;
    {emulAckIn, targetBusReq, breakRequest, respond, boardDataIn, boardDataHiIn} = '0;
    {rst_n, halt_term_n, defib_term, addrStrobe_n} = 4'h7;
    {boardReceiveEn, vector_jam_request_n, in_target_present_n} = 3'h7;
    targetIrqLevel_n = 3'h7;
    fails = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    fork
      begin
        tick();
        t_reset();
        t_regs();
        t_fields();
        t_glue();
        t_jam();
        t_ack();
      end
      begin
        // Ceiling well above the under 200 cycles the scenarios need
        while (cycles < 3000) begin
          @(posedge clk_sys);
          cycles++;
        end
        fails++;
      end
    join_any
    conclude();
  end
endmodule // emulator_pod_register_control_tb
`default_nettype wire

// ---- pod_byte_reg.sv ----
// One byte-wide pod register with write strobe
`timescale 1ns/1ps
`default_nettype none
`include "pod_consts.svh"
module pod_byte_reg
  import pod_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Write side
  input  wire logic         wrEn,
  input  wire pod_byte_type wrData,
  // Stored value
  output var  pod_byte_type value
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value <= `VEC_RESET;
    end else if (wrEn) begin
      value <= wrData;
    end
  end
endmodule // pod_byte_reg
`default_nettype wire

// ---- pod_consts.svh ----
// Pod register control constants
`ifndef POD_CONSTS_SVH
`define POD_CONSTS_SVH
// Selector bit positions
`define SEL_CTRL_BIT    0
`define SEL_VEC_HI_BIT  1
`define SEL_VEC_UM_BIT  2
`define SEL_VEC_LM_BIT  3
`define SEL_VEC_LO_BIT  4
`define SEL_CLEAR_BIT   7
// Control register field positions
`define CTL_DMA_BLOCK   0
`define CTL_TRACE_ONLY  1
`define CTL_REQ_BLOCK   2
`define CTL_ACK_LOCK_N  3
`define CTL_XTAL_N      4
`define CTL_IRQ_ALLOW_N 5
`define CTL_SHARE_N     6
`define CTL_BRK_ALLOW   7
`define CTL_WAIT_LO     8
`define CTL_WAIT_HI     9
// Reset values
`define SEL_RESET       8'h00
`define CTL_RESET       10'h3F8
`define VEC_RESET       8'h00
// Crystal frequency in MHz
`define XTAL_MHZ        10
`endif

// ---- pod_pkg.sv ----
// Pod register control types
package pod_pkg;
  typedef enum logic [1:0] {
    JAM_IDLE,
    JAM_BYTE,
    JAM_DONE
  } jam_state_type;
  typedef logic [7:0] pod_byte_type;
endpackage

// ---- pod_wait_gen.sv ----
// Acknowledge wait-state counter
`timescale 1ns/1ps
`default_nettype none
module pod_wait_gen (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Cycle control
  input  wire logic       cycleActive,
  input  wire logic       ackIn,
  input  wire logic [1:0] waitCount,
  // Delayed acknowledge
  output logic            ackOut
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       ack_nxt;
  assign cnt_nxt = !cycleActive ? 2'h0 :
                   (ackIn && cnt_r != waitCount) ? cnt_r + 2'h1 : cnt_r;
  assign ack_nxt = cycleActive && ackIn && (cnt_r == waitCount);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 2'h0;
      ackOut <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      ackOut <= ack_nxt;
    end
  end
endmodule // pod_wait_gen
`default_nettype wire

// ---- target_ack_model.sv ----
// Target-side transfer acknowledge responder for the pod bench
`timescale 1ns/1ps
`default_nettype none
module target_ack_model #(
  parameter int ACK_DELAY = 2
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Bus observation and control
  input  wire logic busCycle,
  input  wire logic respond,
  // Acknowledge line
  output logic      target_transfer_ack_n
);
  int unsigned waitCnt;
  // ----------------------------------------
  // Acknowledge
  // ----------------------------------------
  // Released line sits at its pull-up level, never at a stale low
  // target acknowledge first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt               <= 0;
      target_transfer_ack_n <= 1'b1;
    end else if (busCycle && respond) begin
      if (waitCnt >= ACK_DELAY) begin
        target_transfer_ack_n <= 1'b0;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end else begin
      waitCnt               <= 0;
      target_transfer_ack_n <= 1'b1;
    end
  end
endmodule // target_ack_model
`default_nettype wire
